//--- rtl/seep_pkg.sv
package seep_pkg;
	// ----------------------------------------
	// Array geometry
	// ----------------------------------------
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          DEPTH           = 256;
	localparam logic [7:0]  PROT_LAST_ADDR  = 8'h7F;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	// ----------------------------------------
	// Bus framing
	// ----------------------------------------
	localparam logic [3:0]  DEV_TYPE_MEM    = 4'hA;
	localparam logic [3:0]  BIT_CNT_LAST    = 4'h8;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_PERIOD_PS   = 25000;
	localparam int          WRITE_TIME_MS   = 5;
	// Scaled to nanoseconds first so the product stays inside 32 bits
	localparam int          WRITE_CYCLES    = (WRITE_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
	// ----------------------------------------
	// Link engine states
	// ----------------------------------------
	typedef enum logic [2:0] {SEEP_IDLE, SEEP_DEVADR, SEEP_WORDADR, SEEP_WDATA, SEEP_RDATA, SEEP_SKIP} seep_state_t;
endpackage : seep_pkg

//--- rtl/seep_top.sv
`timescale 1ns/10ps
// How it works
// - Sample data on clock rising edge; change driven data after falling edge.
// - Data line is only pulled low or released, never driven high.
// - Answer only when address bits match the three strapped address inputs.
// - Write-protect low allows writes everywhere except software-protected areas.
// - Write-protect high refuses every memory write; reads still work.
// - Either software protect register programmed protects first half of array.
// - Internal write starts at Stop ending a write; finishes within write time.
module seep_top #(
	parameter int WRITE_CYCLES = seep_pkg::WRITE_CYCLES
) (
	// System
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// Two-wire link, clocked by the serial clock
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Straps and protection
	input  wire logic [2:0] addr_strap_i,
	input  wire logic       wp_i,
	input  wire logic       perm_prot_i,
	input  wire logic       rev_prot_i,
	// Status
	output logic            busy_o
);
	// ----------------------------------------
	// Link side (serial clock domain)
	// ----------------------------------------
	// Start/stop are seen as data edges while the clock is high; these flops are
	// toggled rather than cleared by the frame, since the serial clock stops outside frames.
	logic                start_seen;
	logic                stop_tgl;
	logic                sda_low;
	seep_pkg::seep_state_t state, next_state;
	logic [3:0]          bit_cnt, next_bit_cnt;
	logic [7:0]          shreg, next_shreg;
	logic [7:0]          word_adr, next_word_adr;
	logic                rd_mode, next_rd_mode;
	logic                ack_phase, next_ack_phase;
	logic                wr_pend, next_wr_pend;
	logic [7:0]          wr_data, next_wr_data;
	logic [7:0]          mem [0:seep_pkg::DEPTH-1];
	logic                busy_l1, busy_l2;
	logic                busy_r, next_busy;

	always_ff @(negedge sda_i or posedge reset_i) begin
		if (reset_i) start_seen <= 1'b0;
		else if (scl_i) start_seen <= ~start_seen;
	end

	logic start_d;
	always_ff @(posedge scl_i or posedge reset_i) begin
		if (reset_i) start_d <= 1'b0;
		else start_d <= start_seen;
	end
	wire start_now = start_seen ^ start_d;

	// Stop toggles on rising data while clock high
	always_ff @(posedge sda_i or posedge reset_i) begin
		if (reset_i) stop_tgl <= 1'b0;
		else if (scl_i) stop_tgl <= ~stop_tgl;
	end

	// Busy from the core, two flops into the link clock
	// Cleared with the link so a stale busy never refuses the first frame
	always_ff @(posedge scl_i or posedge reset_i) begin
		if (reset_i) begin
			busy_l1 <= 1'b0;
			busy_l2 <= 1'b0;
		end else begin
			busy_l1 <= busy_r;
			busy_l2 <= busy_l1;
		end
	end

	// Ninth-clock decisions use the byte already held; only the read state samples the ack bit on the line
	wire [7:0] shifted = {shreg[6:0], sda_i};
	wire       dev_hit = shreg[7:4] == seep_pkg::DEV_TYPE_MEM
			&& shreg[3:1] == addr_strap_i && !busy_l2;

	always_comb begin
		next_state     = state;
		next_bit_cnt   = bit_cnt + 4'h1;
		next_shreg     = shifted;
		next_word_adr  = word_adr;
		next_rd_mode   = rd_mode;
		next_ack_phase = ack_phase;
		next_wr_pend   = wr_pend;
		next_wr_data   = wr_data;
		if (start_now) begin
			next_state   = seep_pkg::SEEP_DEVADR;
			next_bit_cnt = 4'h1;
			next_wr_pend = 1'b0;
		end else if (bit_cnt == seep_pkg::BIT_CNT_LAST) begin
			next_bit_cnt   = 4'h0;
			next_ack_phase = 1'b0;
			case (state)
				seep_pkg::SEEP_DEVADR: begin
					if (dev_hit) begin
						next_rd_mode = shreg[0];
						next_state   = shreg[0] ? seep_pkg::SEEP_RDATA : seep_pkg::SEEP_WORDADR;
					end else begin
						next_state   = seep_pkg::SEEP_SKIP;
					end
				end
				seep_pkg::SEEP_WORDADR: begin
					next_word_adr = shreg;
					next_state    = seep_pkg::SEEP_WDATA;
				end
				seep_pkg::SEEP_WDATA: begin
					next_wr_data = shreg;
					next_wr_pend = 1'b1;
					next_state   = seep_pkg::SEEP_SKIP;
				end
				seep_pkg::SEEP_RDATA: begin
					next_word_adr = word_adr + 8'h01;
					next_state    = sda_i ? seep_pkg::SEEP_SKIP : seep_pkg::SEEP_RDATA;
				end
				default: next_state = seep_pkg::SEEP_SKIP;
			endcase
		end else if (bit_cnt == 4'h0) begin
			next_ack_phase = 1'b1;
		end
	end

	always_ff @(posedge scl_i or posedge reset_i) begin
		if (reset_i) begin
			state     <= seep_pkg::SEEP_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			word_adr  <= 8'h00;
			rd_mode   <= 1'b0;
			ack_phase <= 1'b0;
			wr_pend   <= 1'b0;
			wr_data   <= 8'h00;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shreg     <= next_shreg;
			word_adr  <= next_word_adr;
			rd_mode   <= next_rd_mode;
			ack_phase <= next_ack_phase;
			wr_pend   <= next_wr_pend;
			wr_data   <= next_wr_data;
		end
	end

	// Drive on the falling edge so data is stable over the next high phase
	logic [2:0] rd_bit;
	always_ff @(negedge scl_i or posedge reset_i) begin
		if (reset_i) begin
			sda_low <= 1'b0;
			rd_bit  <= 3'h7;
		end else if (bit_cnt == seep_pkg::BIT_CNT_LAST && state != seep_pkg::SEEP_SKIP
				&& state != seep_pkg::SEEP_RDATA && state != seep_pkg::SEEP_IDLE
				&& (state != seep_pkg::SEEP_DEVADR || dev_hit)) begin
			sda_low <= 1'b1;
			rd_bit  <= 3'h7;
		end else if (state == seep_pkg::SEEP_RDATA && bit_cnt != seep_pkg::BIT_CNT_LAST) begin
			sda_low <= ~mem[word_adr][rd_bit];
			rd_bit  <= rd_bit - 3'h1;
		end else begin
			sda_low <= 1'b0;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_low;

	// ----------------------------------------
	// Core side (reference clock domain)
	// ----------------------------------------
	logic [2:0]  stop_sync;
	logic        wp_s1, wp_s2, pp_s1, pp_s2, rp_s1, rp_s2;
	logic [31:0] wr_cnt, next_wr_cnt;
	logic        allow;

	always_ff @(posedge ref_clk_i) begin
		stop_sync <= {stop_sync[1:0], stop_tgl};
		wp_s1 <= wp_i;
		wp_s2 <= wp_s1;
		pp_s1 <= perm_prot_i;
		pp_s2 <= pp_s1;
		rp_s1 <= rev_prot_i;
		rp_s2 <= rp_s1;
	end

	wire stop_evt = stop_sync[2] ^ stop_sync[1];

	always_comb begin
		allow       = 1'b1;
		next_busy   = busy_r;
		next_wr_cnt = wr_cnt;
		if (wp_s2)
			allow = 1'b0;
		else if ((pp_s2 || rp_s2) && word_adr <= seep_pkg::PROT_LAST_ADDR)
			allow = 1'b0;
		if (busy_r) begin
			next_wr_cnt = wr_cnt - 32'd1;
			if (wr_cnt == 32'd1) next_busy = 1'b0;
		end else if (stop_evt && wr_pend && allow) begin
			next_busy   = 1'b1;
			next_wr_cnt = 32'(WRITE_CYCLES);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			busy_r <= 1'b0;
			wr_cnt <= 32'd0;
		end else begin
			busy_r <= next_busy;
			wr_cnt <= next_wr_cnt;
		end
	end

	// Array commits at the start of the timed cycle; link stays quiet while busy
	always_ff @(posedge ref_clk_i) begin
		if (!busy_r && next_busy) mem[word_adr] <= wr_data;
	end

	assign busy_o = busy_r;
endmodule : seep_top

//--- test/seep_host.sv
`timescale 1ns/10ps
module seep_host (
	// Two-wire link
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	// Released reads high through the pull-up; the host never drives high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Data moves 1 ns after scl falls, so start and stop detection never races
	task automatic bit_io(input logic b, output logic r);
		#1 sda_o = b;
		#2 scl_o = 1'b1;
		r = sda_i;
		#3 scl_o = 1'b0;
	endtask : bit_io
	task automatic start();
		#1 sda_o = 1'b1;
		#2 scl_o = 1'b1;
		#3 sda_o = 1'b0;
		#3 scl_o = 1'b0;
	endtask : start
	task automatic stop();
		#1 sda_o = 1'b0;
		#2 scl_o = 1'b1;
		#3 sda_o = 1'b1;
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(1'b1, r);
	endtask : rbyte
endmodule : seep_host

//--- test/seep_top_assertions.sv
`timescale 1ns/10ps
module seep_top_assertions #(parameter int WRITE_CYCLES = 20) (
	// Clocks and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic scl_i,
	// Link, write protect and status
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic wp_i,
	input wire logic busy_o
);
	int   cnt;
	logic oe_hi;
	always_ff @(posedge ref_clk_i) cnt <= (busy_o && !reset_i) ? cnt + 1 : 0;
	always_ff @(posedge scl_i or posedge reset_i) begin
		if (reset_i) oe_hi <= 1'b0;
		else oe_hi <= sda_oe_o;
	end
	sequence s_bus_idle;
		scl_i && sda_i;
	endsequence
	a_drive_low_only: assert property (@(posedge ref_clk_i) disable iff (reset_i) !sda_o)
		else $error("sda_o driven high");
	a_oe_pulls_line: assert property (@(posedge scl_i) disable iff (reset_i) sda_oe_o |-> !sda_i)
		else $error("line not low while pulled");
	a_oe_scl_low: assert property (@(negedge scl_i) disable iff (reset_i) sda_oe_o == oe_hi)
		else $error("oe moved while scl high");
	a_busy_length: assert property (@(posedge ref_clk_i) disable iff (reset_i) $fell(busy_o) |-> cnt == WRITE_CYCLES)
		else $error("busy length wrong");
	a_wp_no_write: assert property (@(posedge ref_clk_i) disable iff (reset_i) $rose(busy_o) |-> !wp_i)
		else $error("write under wp");
	a_busy_bus_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i) $rose(busy_o) |-> s_bus_idle)
		else $error("busy not after stop");
	a_busy_no_ack: assert property (@(posedge ref_clk_i) disable iff (reset_i) busy_o |-> !sda_oe_o)
		else $error("ack while busy");
	a_reset_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i) $fell(reset_i) |-> !busy_o && !sda_oe_o)
		else $error("outputs active after reset");
endmodule : seep_top_assertions
bind seep_top seep_top_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) seep_top_assertions_i (.ref_clk_i, .reset_i,
	.scl_i, .sda_i, .sda_o, .sda_oe_o, .wp_i, .busy_o);

//--- test/seep_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h", $time, a); end end
module seep_top_tb;
	typedef struct {logic wp, perm, rev; logic [7:0] adr, dat; logic ok;} seep_row_t;
	localparam logic [2:0] STRAP = 3'h5;
	seep_row_t  rows [5] = '{'{0, 0, 0, 8'h00, 8'hA5, 1}, '{0, 1, 0, 8'h7F, 8'h5A, 0},
		'{0, 0, 1, 8'h7F, 8'h66, 0}, '{0, 1, 1, 8'h80, 8'h99, 1}, '{1, 0, 0, 8'hC0, 8'h11, 0}};
	logic       ref_clk_i = 1'b0;
	logic       reset_i = 1'b0, wp_i = 1'b0, perm_prot_i = 1'b0, rev_prot_i = 1'b0;
	logic       scl_i, host_sda, sda_o, sda_oe_o, busy_o, k, s;
	logic [7:0] q;
	int         err_total = 0, n_checks = 0, cyc = 0;
	wire        sda_i = host_sda & ~sda_oe_o;
	always #12.5 ref_clk_i = ~ref_clk_i;
	seep_host seep_host_i (.scl_o(scl_i), .sda_o(host_sda), .sda_i(sda_i));
	seep_top #(.WRITE_CYCLES(20)) seep_top_i (.ref_clk_i, .reset_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
		.addr_strap_i(STRAP), .wp_i, .perm_prot_i, .rev_prot_i, .busy_o);
	task automatic wr(input logic [2:0] st, input logic [7:0] a, input logic [7:0] d, output logic ack);
		logic r;
		seep_host_i.start();
		seep_host_i.wbyte({seep_pkg::DEV_TYPE_MEM, st, 1'b0}, ack);
		seep_host_i.wbyte(a, r);
		seep_host_i.wbyte(d, r);
		seep_host_i.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic r;
		seep_host_i.start();
		seep_host_i.wbyte({seep_pkg::DEV_TYPE_MEM, STRAP, 1'b0}, r);
		seep_host_i.wbyte(a, r);
		seep_host_i.start();
		seep_host_i.wbyte({seep_pkg::DEV_TYPE_MEM, STRAP, 1'b1}, r);
		seep_host_i.rbyte(d);
		seep_host_i.stop();
	endtask : rd
	// Window covers the start delay plus the full busy time
	task automatic settle(output logic seen);
		seen = 1'b0;
		repeat (40) @(posedge ref_clk_i) if (busy_o === 1'b1) seen = 1'b1;
	endtask : settle
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		// A real rising edge, so the asynchronously cleared link flops leave X
		#2 reset_i = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#2 reset_i = 1'b0;
		foreach (rows[i]) begin
			wr(STRAP, rows[i].adr, 8'h3C, k);
			`CHK(k, 1'b1)
			settle(s);
		end
		foreach (rows[i]) begin
			@(posedge ref_clk_i);
			#2 {wp_i, perm_prot_i, rev_prot_i} = {rows[i].wp, rows[i].perm, rows[i].rev};
			wr(STRAP, rows[i].adr, rows[i].dat, k);
			settle(s);
			`CHK(s, rows[i].ok)
			rd(rows[i].adr, q);
			`CHK(q, (rows[i].ok ? rows[i].dat : 8'h3C))
		end
		@(posedge ref_clk_i);
		#2 {wp_i, perm_prot_i, rev_prot_i} = 3'h0;
		wr(STRAP ^ 3'h1, 8'h10, 8'h77, k);
		`CHK(k, 1'b0)
		wr(STRAP, 8'h20, 8'h42, k);
		`CHK(k, 1'b1)
		repeat (6) @(posedge ref_clk_i);
		wr(STRAP, 8'h21, 8'h43, k);
		`CHK(k, 1'b0)
		// Reset lands while the internal write is still running
		@(posedge ref_clk_i);
		#2 reset_i = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#2 reset_i = 1'b0;
		`CHK(busy_o, 1'b0)
		`CHK(sda_o, 1'b0)
		// Array commits at the start of the timed cycle, so the cut write is kept
		rd(8'h20, q);
		`CHK(q, 8'h42)
		close_out();
	end
endmodule : seep_top_tb
